// File: srdt_pkg.sv
/*
  Constants, register map and state types of the serial port block.
  Assumes a 200 MHz system clock and a byte-wide special-register bus.
*/
package srdt_pkg;
  // ==========================================
  // Register map
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  ADDR_CLK_DIV  = 8'ha2;
  localparam logic [7:0]  ADDR_DATA     = 8'ha3;
  localparam logic [7:0]  RATE_RESET    = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
  // ==========================================
  // Transfer shape
  localparam logic [3:0]  HALF_LAST     = 4'hf;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam int          FIFO_DEPTH    = 4;
  // ==========================================
  // Timing
  localparam int          SYSTEM_CLOCK_NS     = 5;
  localparam int          SEZ_MAX_NS    = 20;
  localparam int          SEZ_CYC       = SEZ_MAX_NS / SYSTEM_CLOCK_NS;
  localparam int          SLH_MIN_NS    = 30;
  localparam int          SLH_MAX_NS    = 40;
  localparam int          SLH_MIN_CYC   = (SLH_MIN_NS + SYSTEM_CLOCK_NS - 1) / SYSTEM_CLOCK_NS;
  localparam int          SLH_MAX_CYC   = SLH_MAX_NS / SYSTEM_CLOCK_NS;
  localparam int          SYNC_LAT      = 3;
  localparam logic [3:0]  LAST_WAIT     = 4'(SLH_MIN_CYC + 1 - SYNC_LAT);
  // ==========================================
  // States
  typedef enum logic [0:0] {MS_IDLE, MS_RUN} srdt_mstate_type;
  typedef enum logic [1:0] {SS_IDLE, SS_ACTIVE, SS_TAIL} srdt_sstate_type;
endpackage

// File: srdt_stream_if.sv
/*
  Valid/ready byte stream between the register side and the transmit FIFO.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/100ps
interface srdt_stream_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fill  (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
  modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

// File: srdt_fifo.sv
/*
  Transmit FIFO, flip-flop storage, parameterised width and depth.
  Assumes synchronous active-high reset; depth is a power of two.
*/
`timescale 1ns/100ps
module srdt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  srdt_stream_if.store st
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             do_push, do_pop;

  assign st.push_ready = (cnt_r != (AW+1)'(DEPTH));
  assign st.pop_valid  = (cnt_r != '0);
  assign st.pop_data   = mem_r[rd_r];

  always_comb begin
    do_push = st.push_valid && st.push_ready;
    do_pop  = st.pop_ready && st.pop_valid;
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (do_push) begin
      mem_nxt[wr_r] = st.push_data;
      wr_nxt        = wr_r + 1'b1;
    end
    if (do_pop) begin
      rd_nxt = rd_r + 1'b1;
    end
    if (do_push && !do_pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule

// File: srdt_top.sv
/*
  Serial peripheral port: clock divider, data port with transmit FIFO,
  master shifter and slave shifter with synchronised pin inputs.
  Assumes mode and polarity inputs change only while the port is idle.
*/
`timescale 1ns/100ps
module srdt_top
  import srdt_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic                    sfr_wr,
  input  wire logic                    sfr_rd,
  input  wire logic [srdt_pkg::DATA_W-1:0] sfr_wdata,
  output logic      [srdt_pkg::DATA_W-1:0] sfr_rdata,
  input  wire logic                    master_mode,
  input  wire logic                    clock_polarity_select,
  input  wire logic                    clock_phase_select,
  input  wire logic [2:0]              flag_clear,
  output logic                         transfer_complete_flag,
  output logic                         write_collision_flag,
  output logic                         receive_overrun_flag,
  output logic                         port_irq,
  input  wire logic                    sck_i,
  output logic                         sck_o,
  output logic                         sck_oe_n,
  input  wire logic                    mosi_i,
  output logic                         mosi_o,
  output logic                         mosi_oe_n,
  input  wire logic                    miso_i,
  output logic                         miso_o,
  output logic                         miso_oe_n,
  input  wire logic                    nss_i
);
  import srdt_pkg::*;

  srdt_stream_if #(.WIDTH(DATA_W)) st ();
  srdt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .st      (st.store)
  );

  // ==========================================
  // State
  logic [7:0]        rate_r, rate_nxt, rdata_r, rdata_nxt, rx_buf_r, rx_buf_nxt;
  logic              rx_full_r, rx_full_nxt, done_r, done_nxt, coll_r, coll_nxt;
  logic              ovr_r, ovr_nxt, irq_r, irq_nxt;
  srdt_mstate_type   m_state_r, m_state_nxt;
  logic [7:0]        div_r, div_nxt, m_tx_r, m_tx_nxt, m_rx_r, m_rx_nxt;
  logic [3:0]        half_r, half_nxt;
  logic              sck_r, sck_nxt, mosi_r, mosi_nxt;
  logic              sck_s1_r, sck_s2_r, sck_s3_r, nss_s1_r, nss_s2_r, nss_s3_r;
  logic              mosi_s1_r, mosi_s2_r;
  srdt_sstate_type   s_state_r, s_state_nxt;
  logic [7:0]        s_tx_r, s_tx_nxt, s_rx_r, s_rx_nxt;
  logic [2:0]        s_bit_r, s_bit_nxt;
  logic [3:0]        s_wait_r, s_wait_nxt;
  logic              miso_r, miso_nxt, miso_oe_n_r, miso_oe_n_nxt, pin_oe_n_r, pin_oe_n_nxt;
  logic              xfer_done, busy, wr_data, rd_data;
  logic              act, act_prev, lead, trail, s_sample, s_shift;
  logic [7:0]        done_byte;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  // ==========================================
  // Next-state logic
  always_comb begin
    rate_nxt      = rate_r;
    rx_buf_nxt    = rx_buf_r;
    rx_full_nxt   = rx_full_r;
    m_state_nxt   = m_state_r;
    div_nxt       = div_r;
    half_nxt      = half_r;
    m_tx_nxt      = m_tx_r;
    m_rx_nxt      = m_rx_r;
    sck_nxt       = clock_polarity_select;
    mosi_nxt      = mosi_r;
    s_state_nxt   = s_state_r;
    s_tx_nxt      = s_tx_r;
    s_rx_nxt      = s_rx_r;
    s_bit_nxt     = s_bit_r;
    s_wait_nxt    = s_wait_r;
    miso_nxt      = miso_r;
    miso_oe_n_nxt = miso_oe_n_r;
    pin_oe_n_nxt  = !master_mode;
    xfer_done     = 1'b0;
    done_byte     = rx_buf_r;
    st.pop_ready  = 1'b0;
    wr_data       = sfr_wr && hit(sfr_addr, ADDR_DATA);
    rd_data       = sfr_rd && hit(sfr_addr, ADDR_DATA);
    busy          = (m_state_r != MS_IDLE) || (!master_mode && s_state_r != SS_IDLE);
    // Full FIFO is refused the same way as a busy port, so a write never vanishes silently
    st.push_valid = wr_data && !busy;
    st.push_data  = sfr_wdata;
    // Slave edges come only from the second and third synchroniser stages
    act      = sck_s2_r ^ clock_polarity_select;
    act_prev = sck_s3_r ^ clock_polarity_select;
    lead     = act && !act_prev;
    trail    = !act && act_prev;
    s_sample = clock_phase_select ? trail : lead;
    s_shift  = clock_phase_select ? lead : trail;
    if (sfr_wr && hit(sfr_addr, ADDR_CLK_DIV)) begin
      rate_nxt = sfr_wdata;
    end
    rdata_nxt = READ_ZERO;
    if (sfr_rd && hit(sfr_addr, ADDR_CLK_DIV)) begin
      rdata_nxt = rate_r;
    end else if (rd_data) begin
      rdata_nxt = rx_buf_r;
    end
    case (m_state_r)
      MS_IDLE: begin
        if (master_mode && st.pop_valid) begin
          st.pop_ready = 1'b1;
          m_tx_nxt     = st.pop_data;
          mosi_nxt     = st.pop_data[7];
          div_nxt      = '0;
          half_nxt     = '0;
          m_state_nxt  = MS_RUN;
        end
      end
      MS_RUN: begin
        if (div_r == rate_r) begin
          div_nxt = '0;
          if (half_r[0]) begin
            m_rx_nxt = {m_rx_r[6:0], miso_i};
            m_tx_nxt = {m_tx_r[6:0], 1'b0};
            mosi_nxt = m_tx_r[6];
          end
          if (half_r == HALF_LAST) begin
            xfer_done   = 1'b1;
            done_byte   = {m_rx_r[6:0], miso_i};
            m_state_nxt = MS_IDLE;
          end else begin
            half_nxt = half_r + 1'b1;
          end
        end else begin
          div_nxt = div_r + 1'b1;
        end
      end
      default: m_state_nxt = MS_IDLE;
    endcase
    // Level tracks the half count of the coming cycle, so SCK edges land where MOSI moves
    sck_nxt = (m_state_nxt == MS_RUN) ? (clock_polarity_select ^ clock_phase_select ^ half_nxt[0]) : clock_polarity_select;
    case (s_state_r)
      SS_IDLE: begin
        miso_oe_n_nxt = 1'b1;
        if (!master_mode && nss_s3_r && !nss_s2_r) begin
          st.pop_ready  = st.pop_valid;
          s_tx_nxt      = st.pop_valid ? st.pop_data : DATA_RESET;
          miso_nxt      = st.pop_valid ? st.pop_data[7] : 1'b0;
          miso_oe_n_nxt = 1'b0;
          s_bit_nxt     = '0;
          s_state_nxt   = SS_ACTIVE;
        end
      end
      SS_ACTIVE: begin
        if (s_shift && clock_phase_select) begin
          miso_nxt = s_tx_r[7];
          s_tx_nxt = {s_tx_r[6:0], 1'b0};
        end else if (s_shift) begin
          miso_nxt = s_tx_r[6];
          s_tx_nxt = {s_tx_r[6:0], 1'b0};
        end
        if (s_sample) begin
          s_rx_nxt  = {s_rx_r[6:0], mosi_s2_r};
          s_bit_nxt = s_bit_r + 1'b1;
          if (s_bit_r == BIT_LAST) begin
            xfer_done   = 1'b1;
            done_byte   = {s_rx_r[6:0], mosi_s2_r};
            s_wait_nxt  = '0;
            s_state_nxt = SS_TAIL;
          end
        end
      end
      SS_TAIL: begin
        if (s_wait_r != LAST_WAIT) begin
          s_wait_nxt = s_wait_r + 1'b1;
        end
        if (clock_phase_select && s_wait_r + 1'b1 == LAST_WAIT) begin
          miso_nxt = 1'b0;
        end
      end
      default: s_state_nxt = SS_IDLE;
    endcase
    // NSS release overrides the next slave state and MISO enable chosen above; a completion in the same cycle still counts
    if (s_state_r != SS_IDLE && !nss_s3_r && nss_s2_r) begin
      miso_oe_n_nxt = 1'b1;
      s_state_nxt   = SS_IDLE;
    end
    // Flags: a set in the same cycle as its clear wins
    done_nxt = (done_r && !flag_clear[0]) || xfer_done;
    coll_nxt = (coll_r && !flag_clear[1]) || (wr_data && (busy || !st.push_ready));
    ovr_nxt  = (ovr_r && !flag_clear[2]) || (xfer_done && !master_mode && rx_full_r && !rd_data);
    if (rd_data) begin
      rx_full_nxt = 1'b0;
    end
    if (xfer_done) begin
      rx_buf_nxt  = done_byte;
      rx_full_nxt = 1'b1;
    end
    irq_nxt = done_nxt || coll_nxt || ovr_nxt;
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rate_r      <= RATE_RESET;
      rdata_r     <= READ_ZERO;
      rx_buf_r    <= DATA_RESET;
      rx_full_r   <= 1'b0;
      done_r      <= 1'b0;
      coll_r      <= 1'b0;
      ovr_r       <= 1'b0;
      irq_r       <= 1'b0;
      m_state_r   <= MS_IDLE;
      div_r       <= '0;
      half_r      <= '0;
      m_tx_r      <= DATA_RESET;
      m_rx_r      <= DATA_RESET;
      sck_r       <= 1'b0;
      mosi_r      <= 1'b0;
      sck_s1_r    <= 1'b0;
      sck_s2_r    <= 1'b0;
      sck_s3_r    <= 1'b0;
      nss_s1_r    <= 1'b1;
      nss_s2_r    <= 1'b1;
      nss_s3_r    <= 1'b1;
      mosi_s1_r   <= 1'b0;
      mosi_s2_r   <= 1'b0;
      s_state_r   <= SS_IDLE;
      s_tx_r      <= DATA_RESET;
      s_rx_r      <= DATA_RESET;
      s_bit_r     <= '0;
      s_wait_r    <= '0;
      miso_r      <= 1'b0;
      miso_oe_n_r <= 1'b1;
      pin_oe_n_r  <= 1'b1;
    end else begin
      rate_r      <= rate_nxt;
      rdata_r     <= rdata_nxt;
      rx_buf_r    <= rx_buf_nxt;
      rx_full_r   <= rx_full_nxt;
      done_r      <= done_nxt;
      coll_r      <= coll_nxt;
      ovr_r       <= ovr_nxt;
      irq_r       <= irq_nxt;
      m_state_r   <= m_state_nxt;
      div_r       <= div_nxt;
      half_r      <= half_nxt;
      m_tx_r      <= m_tx_nxt;
      m_rx_r      <= m_rx_nxt;
      sck_r       <= sck_nxt;
      mosi_r      <= mosi_nxt;
      sck_s1_r    <= sck_i;
      sck_s2_r    <= sck_s1_r;
      sck_s3_r    <= sck_s2_r;
      nss_s1_r    <= nss_i;
      nss_s2_r    <= nss_s1_r;
      nss_s3_r    <= nss_s2_r;
      mosi_s1_r   <= mosi_i;
      mosi_s2_r   <= mosi_s1_r;
      s_state_r   <= s_state_nxt;
      s_tx_r      <= s_tx_nxt;
      s_rx_r      <= s_rx_nxt;
      s_bit_r     <= s_bit_nxt;
      s_wait_r    <= s_wait_nxt;
      miso_r      <= miso_nxt;
      miso_oe_n_r <= miso_oe_n_nxt;
      pin_oe_n_r  <= pin_oe_n_nxt;
    end
  end

  assign sfr_rdata              = rdata_r;
  assign transfer_complete_flag = done_r;
  assign write_collision_flag   = coll_r;
  assign receive_overrun_flag   = ovr_r;
  assign port_irq               = irq_r;
  assign sck_o                  = sck_r;
  assign mosi_o                 = mosi_r;
  assign sck_oe_n               = pin_oe_n_r;
  assign mosi_oe_n              = pin_oe_n_r;
  assign miso_o                 = miso_r;
  assign miso_oe_n              = miso_oe_n_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_nss_fall;
    !master_mode && $fell(nss_i);
  endsequence
  sequence s_nss_rise;
    $rose(nss_i) && s_state_r != SS_IDLE;
  endsequence

  rate_write_a: assert property (sfr_wr && hit(sfr_addr, ADDR_CLK_DIV) |=> rate_r == $past(sfr_wdata))
    else $error("rate field not written");
  sck_hold_a: assert property (m_state_r == MS_RUN && div_r != rate_r |=> $stable(sck_r))
    else $error("sck moved inside a half period");
  data_start_a: assert property (wr_data && !busy && st.push_ready && master_mode |-> ##[1:2] m_state_r == MS_RUN)
    else $error("data write did not start transfer");
  data_read_a: assert property (rd_data |=> sfr_rdata == $past(rx_buf_r))
    else $error("data read not from receive buffer");
  idle_pol_a: assert property ((m_state_r == MS_IDLE && $stable(clock_polarity_select))[*2] |-> sck_o == clock_polarity_select)
    else $error("idle sck level wrong");
  miso_on_a: assert property (s_nss_fall |-> ##[1:4] (!miso_oe_n || nss_i))
    else $error("miso not driven in time");
  miso_off_a: assert property (s_nss_rise |-> ##[1:4] miso_oe_n)
    else $error("miso not released in time");
  done_set_a: assert property (xfer_done |=> transfer_complete_flag && rx_full_r)
    else $error("completion flag missed");
  coll_set_a: assert property (wr_data && busy |=> write_collision_flag && port_irq)
    else $error("collision flag missed");
  ovr_set_a: assert property (xfer_done && !master_mode && rx_full_r && !rd_data |=> receive_overrun_flag)
    else $error("overrun flag missed");
endmodule

// File: srdt_partner.sv
/*
  Far-side model of the serial port: a slave that answers the device in
  master mode, and a master that runs frames against the device in slave mode.
  Assumes clock phase 0 in the slave role, either phase in the master role,
  and that the bench calls frame and load at a falling edge.
*/
`timescale 1ns/100ps
module srdt_partner (
  input  wire logic clk_sys,
  input  wire logic master_mode,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      psck,
  output logic      pmosi,
  output logic      pmiso,
  output logic      nss
);
  // ==========================================
  // Slave role
  localparam int HALF = 6;
  logic [7:0] sh_r;
  logic [7:0] rx_r;

  initial begin
    psck = 1'b0;
    pmosi = 1'b0;
    pmiso = 1'b0;
    nss = 1'b1;
    sh_r = 8'h00;
    rx_r = 8'h00;
  end

  // Reacts just after each edge so the device sees settled data at its next clock
  always @(sck) begin
    #1;
    if (master_mode && sck !== cpol) begin
      rx_r = {rx_r[6:0], mosi};
    end else if (master_mode) begin
      // Stale bits are replaced by a toggling pattern, never held
      sh_r = {sh_r[6:0], ~sh_r[0]};
      pmiso = sh_r[7];
    end
  end

  task automatic load(input logic [7:0] b);
    sh_r = b;
    pmiso = b[7];
  endtask

  // ==========================================
  // Master role
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx, output logic [1:0] st, output logic tail);
    nss = 1'b0;
    repeat (4) @(negedge clk_sys);
    st[1] = miso_oe_n;
    repeat (HALF - 4) @(negedge clk_sys);
    for (int i = 7; i >= 0; i--) begin
      // Phase 0 presents data before the leading edge, phase 1 on it
      if (!cpha) begin
        pmosi = tx[i];
      end
      repeat (HALF) @(negedge clk_sys);
      if (!cpha) begin
        rx[i] = miso;
      end
      psck = ~cpol;
      if (cpha) begin
        pmosi = tx[i];
      end
      repeat (HALF) @(negedge clk_sys);
      if (cpha) begin
        rx[i] = miso;
      end
      psck = cpol;
    end
    repeat (HALF + 1) @(negedge clk_sys);
    tail = miso;
    nss = 1'b1;
    pmosi = ~pmosi;
    repeat (4) @(negedge clk_sys);
    st[0] = miso_oe_n;
  endtask
endmodule

// File: test_spi_rate_data_and_timing.sv
/*
  Self-checking bench for the serial port: registers, master transfers at
  several rates and polarities, collisions, and slave frames through the FIFO.
  Assumes the far-side model in srdt_partner and inputs driven at falling edges.
*/
`timescale 1ns/100ps
module test_spi_rate_data_and_timing;
  import srdt_pkg::*;
  logic       clk_sys, reset, sfr_wr, sfr_rd, master_mode, cpol, cpha;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [2:0] flag_clear;
  logic       tcf, wcf, rof, port_irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic       psck, pmosi, pmiso, nss, sck_q;
  wire        sck_w = sck_oe_n ? psck : sck_o;
  wire        mosi_w = mosi_oe_n ? pmosi : mosi_o;
  wire        miso_w = miso_oe_n ? pmiso : miso_o;
  int         bad_count = 0;
  int         check_count = 0;
  int         edges = 0;
  int         gap = 0;
  int         cnt = 0;

  srdt_top u_dut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .master_mode(master_mode), .clock_polarity_select(cpol),
    .clock_phase_select(cpha), .flag_clear(flag_clear), .transfer_complete_flag(tcf),
    .write_collision_flag(wcf), .receive_overrun_flag(rof), .port_irq(port_irq), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .nss_i(nss));

  srdt_partner u_partner (.clk_sys(clk_sys), .master_mode(master_mode), .cpol(cpol), .cpha(cpha), .sck(sck_w),
    .mosi(mosi_w), .miso(miso_w), .miso_oe_n(miso_oe_n), .psck(psck), .pmosi(pmosi), .pmiso(pmiso), .nss(nss));

  always #2.5 clk_sys = ~clk_sys;

  // Half-period meter on the driven clock
  always @(posedge clk_sys) begin
    if (sck_o !== sck_q) begin
      edges <= edges + 1;
      gap <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    sck_q <= sck_o;
  end

  // ==========================================
  // Compare and bus tasks
  task automatic chkv(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask

  task automatic clr(input logic [2:0] m);
    @(negedge clk_sys);
    flag_clear = m;
    @(negedge clk_sys);
    flag_clear = 3'b000;
    @(negedge clk_sys);
  endtask

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (tcf !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk1("transfer complete", 1'b1, tcf);
  endtask

  // ==========================================
  // Scenarios
  task automatic master_xfer(input logic [7:0] rate, input logic pol, input logic [7:0] tx, input logic [7:0] prx);
    int e0;
    master_mode = 1'b1;
    cpol = pol;
    wr(ADDR_CLK_DIV, rate);
    rd(ADDR_CLK_DIV, d);
    chkv("divider readback", 16'(rate), 16'(d));
    chk1("sck idle level", pol, sck_o);
    u_partner.load(prx);
    e0 = edges;
    wr(ADDR_DATA, tx);
    @(negedge clk_sys);
    wr(ADDR_DATA, ~tx);
    @(negedge clk_sys);
    chk1("collision flag", 1'b1, wcf);
    chk1("port interrupt", 1'b1, port_irq);
    wait_done(32 * int'(rate) + 64);
    repeat (2) @(negedge clk_sys);
    chkv("slave received", 16'(tx), 16'(u_partner.rx_r));
    chkv("sck edges", 16'h0010, 16'(edges - e0));
    chkv("half period", 16'(rate) + 16'h0001, 16'(gap));
    chk1("sck idle after", pol, sck_o);
    rd(ADDR_DATA, d);
    chkv("receive buffer", 16'(prx), 16'(d));
    chk1("completion sticky", 1'b1, tcf);
    clr(3'b111);
    chk1("completion cleared", 1'b0, tcf);
    chk1("interrupt cleared", 1'b0, port_irq);
  endtask

  task automatic slave_run();
    logic [7:0] got;
    logic [1:0] st;
    logic       tail;
    master_mode = 1'b0;
    cpol = 1'b0;
    // One write past the depth must be refused
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      wr(ADDR_DATA, 8'h90 + 8'(i));
    end
    @(negedge clk_sys);
    chk1("full buffer collision", 1'b1, wcf);
    clr(3'b010);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      u_partner.frame(8'h30 + 8'(i), got, st, tail);
      chkv("slave sent byte", 16'h0090 + 16'(i), 16'(got));
      chk1("tail level", i[0], tail);
      chk1("miso driven", 1'b0, st[1]);
      chk1("miso released", 1'b1, st[0]);
      chk1("slave completion", 1'b1, tcf);
      chk1("overrun", i >= 2, rof);
      if (i == 0) begin
        rd(ADDR_DATA, d);
        chkv("slave receive buffer", 16'h0030, 16'(d));
      end
      clr(3'b001);
    end
  endtask

  task automatic slave_phase();
    logic [7:0] got;
    logic [1:0] st;
    logic       tail;
    master_mode = 1'b0;
    cpha = 1'b1;
    wr(ADDR_DATA, 8'h4b);
    u_partner.frame(8'hc6, got, st, tail);
    chkv("phase one sent byte", 16'h004b, 16'(got));
    chk1("phase one driven", 1'b0, st[1]);
    chk1("phase one released", 1'b1, st[0]);
    chk1("phase one tail level", 1'b0, tail);
    rd(ADDR_DATA, d);
    chkv("phase one receive", 16'h00c6, 16'(d));
    cpha = 1'b0;
  endtask

  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    finish_test();
  end

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    master_mode = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    flag_clear = 3'b000;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    rd(ADDR_CLK_DIV, d);
    chkv("divider reset", 16'(RATE_RESET), 16'(d));
    rd(ADDR_DATA, d);
    chkv("data reset", 16'(DATA_RESET), 16'(d));
    rd(8'h00, d);
    chkv("unmapped read", 16'(READ_ZERO), 16'(d));
    master_xfer(8'h00, 1'b0, 8'ha5, 8'h5a);
    master_xfer(8'h03, 1'b1, 8'h0f, 8'hc3);
    master_xfer(8'hff, 1'b0, 8'h81, 8'h7e);
    slave_run();
    slave_phase();
    finish_test();
  end
endmodule
